/* logic/sadc_clk_tick.sv */
`timescale 1ns/1ps
// converter clock enable: every cycle when fast, every other cycle otherwise
module sadc_clk_tick
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // control
    input wire logic run,
    input wire logic fast,
    // tick out
    output logic tick
);
    logic phase_r;
    logic phase_nxt;

    always_comb
    begin
        phase_nxt = run ? ~phase_r : 1'b0;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            phase_r <= 1'b0;
        else if (clk_en)
            phase_r <= phase_nxt;
    end

    assign tick = clk_en & run & (fast | phase_r);
endmodule : sadc_clk_tick

/* logic/sadc_ctrl.sv */
// Function
// - conversion result is 10 bits, held in software-readable result registers
// - converts one of up to 16 inputs picked by the channel field
// - setting the on bit at bit 5 powers up and starts converting
// - conversions repeat back to back until the on bit is cleared
// - each completion loads result registers and sets done flag bit 7
// - reading the high result byte is the only way to clear done
// - input above high reference gives high FFh and low 03h, no overflow
// - input below low reference gives zero in both bytes
// - speed bit 6: converter clock half rate at 0, full rate at 1
// - control register read/write except done flag and reserved bit 4, which ignore writes
// - control register resets to 00h
// - clearing the on bit stops conversion and powers the converter down
// - cpu wait mode leaves converter operation unchanged
// - halt disables converter; software waits stabilisation time after wakeup
// - analog use of a pin does not stop it being read as logic
// - no interrupt; completion is learned only by polling done
// - channel value n in bits 3:0 selects analog input n
// - high byte holds bits 9:2, low byte bits 1:0, upper bits zero
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_ctrl
#(
    parameter int CHANNELS = 16,
    parameter int ADDR_W = 8
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power modes
    input wire logic cpu_wait,
    input wire logic cpu_halt,
    // analog front end
    output logic [3:0] analog_mux_select,
    output logic converter_power,
    output logic sample_hold,
    output logic [9:0] dac_trial,
    input wire logic comparator_above,
    // port pins shared with analog inputs
    input wire logic [CHANNELS-1:0] port_pin,
    output logic [CHANNELS-1:0] port_pin_level
);
    logic [CHANNELS-1:0] pin_meta_r;
    logic [CHANNELS-1:0] pin_sync_r;
    logic cmp_meta_r;
    logic cmp_sync_r;
    logic done_r;
    logic done_nxt;
    logic fast_r;
    logic fast_nxt;
    logic on_r;
    logic on_nxt;
    logic [3:0] chan_r;
    logic [3:0] chan_nxt;
    sadc_pkg::sadc_result_t result_r;
    sadc_pkg::sadc_result_t result_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    sadc_pkg::sadc_state_t state_r;
    sadc_pkg::sadc_state_t state_nxt;
    logic [3:0] slot_r;
    logic [3:0] slot_nxt;
    logic run;
    logic tick;
    logic sar_start;
    logic sar_step;
    logic sar_done;
    logic [9:0] sar_trial;
    logic csr_sel;
    logic drh_sel;
    logic drl_sel;
    logic finish;

    initial
    begin
        if (CHANNELS < 1 || CHANNELS > 16)
            $error("sadc_ctrl: CHANNELS must be 1 to 16");
        if (ADDR_W < 8)
            $error("sadc_ctrl: ADDR_W must be at least 8");
    end

    assign csr_sel = (reg_addr == ADDR_W'(`SADC_OFS_CSR));
    assign drh_sel = (reg_addr == ADDR_W'(`SADC_OFS_DRH));
    assign drl_sel = (reg_addr == ADDR_W'(`SADC_OFS_DRL));

    // halt powers the converter down; wait mode is not an input to run at all
    assign run = on_r & ~cpu_halt;

    // pins and comparator are asynchronous to ref_clk: two stages each
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_pin
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    pin_meta_r[gi] <= port_pin[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end
        else if (clk_en)
        begin
            cmp_meta_r <= comparator_above;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    sadc_clk_tick u_tick
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .run(run),
        .fast(fast_r),
        .tick(tick)
    );

    sadc_sar #(.WIDTH(10)) u_sar
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(sar_start),
        .step(sar_step),
        .cmp_above(cmp_sync_r),
        .trial(sar_trial),
        .done(sar_done)
    );

    // conversion sequencer
    // the comparator is read two cycles late through its synchroniser, so each
    // decision waits two extra settle slots; the trade is speed for a clean crossing
    always_comb
    begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        sar_start = 1'b0;
        sar_step = 1'b0;
        finish = 1'b0;
        if (!run)
        begin
            state_nxt = sadc_pkg::SADC_IDLE;
            slot_nxt = 4'h0;
        end
        else
        begin
            case (state_r)
                sadc_pkg::SADC_IDLE:
                begin
                    state_nxt = sadc_pkg::SADC_SAMPLE;
                    slot_nxt = 4'h0;
                end
                sadc_pkg::SADC_SAMPLE:
                begin
                    if (tick)
                    begin
                        if (slot_r + 4'h1 >= `SADC_SAMPLE_CLKS)
                        begin
                            state_nxt = sadc_pkg::SADC_CONVERT;
                            sar_start = 1'b1;
                            slot_nxt = 4'h0;
                        end
                        else
                            slot_nxt = slot_r + 4'h1;
                    end
                end
                sadc_pkg::SADC_CONVERT:
                begin
                    // a step on a stale comparison would decide on the previous trial
                    if (sar_done)
                        state_nxt = sadc_pkg::SADC_STORE;
                    else if (tick && slot_r >= `SADC_SETTLE_CLKS)
                    begin
                        sar_step = 1'b1;
                        slot_nxt = 4'h0;
                    end
                    else if (slot_r < `SADC_SETTLE_CLKS)
                        slot_nxt = slot_r + 4'h1;
                end
                sadc_pkg::SADC_STORE:
                begin
                    finish = 1'b1;
                    state_nxt = sadc_pkg::SADC_SAMPLE;
                    slot_nxt = 4'h0;
                end
                default:
                begin
                    state_nxt = sadc_pkg::SADC_IDLE;
                    slot_nxt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= sadc_pkg::SADC_IDLE;
            slot_r <= 4'h0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
        end
    end

    // control/status and result registers
    always_comb
    begin
        fast_nxt = fast_r;
        on_nxt = on_r;
        chan_nxt = chan_r;
        done_nxt = done_r;
        result_nxt = result_r;
        if (reg_wr && csr_sel)
        begin
            // done flag and reserved bit are not writable
            fast_nxt = reg_wdata[`SADC_CSR_FAST_BIT];
            on_nxt = reg_wdata[`SADC_CSR_ON_BIT];
            chan_nxt = reg_wdata[`SADC_CSR_CH_HI:`SADC_CSR_CH_LO];
        end
        if (reg_rd && drh_sel)
            done_nxt = 1'b0;
        if (finish)
        begin
            // both bytes from one conversion; set beats a same-cycle clear
            result_nxt = sar_trial;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            fast_r <= 1'b0;
            on_r <= 1'b0;
            chan_r <= 4'h0;
            done_r <= 1'b0;
            result_r <= `SADC_DATA_RESET;
        end
        else if (clk_en)
        begin
            fast_r <= fast_nxt;
            on_r <= on_nxt;
            chan_r <= chan_nxt;
            done_r <= done_nxt;
            result_r <= result_nxt;
        end
    end

    // read data, one cycle after the strobe; unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            if (csr_sel)
            begin
                rdata_nxt[`SADC_CSR_DONE_BIT] = done_r;
                rdata_nxt[`SADC_CSR_FAST_BIT] = fast_r;
                rdata_nxt[`SADC_CSR_ON_BIT] = on_r;
                rdata_nxt[`SADC_CSR_CH_HI:`SADC_CSR_CH_LO] = chan_r;
            end
            else if (drh_sel)
                rdata_nxt = result_r[9:2];
            else if (drl_sel)
                rdata_nxt = {6'h00, result_r[1:0]};
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            rdata_r <= 8'h00;
        else if (clk_en)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
    assign analog_mux_select = chan_r;
    assign converter_power = run;
    assign sample_hold = (state_r == sadc_pkg::SADC_SAMPLE);
    assign dac_trial = sar_trial;
    assign port_pin_level = pin_sync_r;
endmodule : sadc_ctrl

/* logic/sadc_params.svh */
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// register offsets (printed addresses, low byte)
`define SADC_OFS_CSR 8'h70
`define SADC_OFS_DRH 8'h71
`define SADC_OFS_DRL 8'h72

// control/status field positions
`define SADC_CSR_DONE_BIT 7
`define SADC_CSR_FAST_BIT 6
`define SADC_CSR_ON_BIT 5
`define SADC_CSR_RSVD_BIT 4
`define SADC_CSR_CH_HI 3
`define SADC_CSR_CH_LO 0

// reset values
`define SADC_CSR_RESET 8'h00
`define SADC_DATA_RESET 10'h000

// timing: one sample slot plus ten bit decisions, in converter clocks
`define SADC_SAMPLE_CLKS 4'h1
`define SADC_BIT_COUNT 4'hA
// clocks a trial must stand before its comparison has crossed both sync stages
`define SADC_SETTLE_CLKS 4'h2

`endif

/* logic/sadc_pkg.sv */
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_CONVERT = 2'b10,
        SADC_STORE = 2'b11
    } sadc_state_t;
    typedef logic [9:0] sadc_result_t;
endpackage : sadc_pkg

/* logic/sadc_sar.sv */
`timescale 1ns/1ps
// successive approximation register: one trial bit per step pulse, msb first
module sadc_sar
#(
    parameter int WIDTH = 10
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // control
    input wire logic start,
    input wire logic step,
    input wire logic cmp_above,
    // result
    output logic [WIDTH-1:0] trial,
    output logic done
);
    logic [WIDTH-1:0] trial_r;
    logic [WIDTH-1:0] trial_nxt;
    logic [WIDTH-1:0] mask_r;
    logic [WIDTH-1:0] mask_nxt;

    initial
    begin
        if (WIDTH < 2 || WIDTH > 16)
            $error("sadc_sar: WIDTH out of range");
    end

    // a bit is kept when the input is at or above the trial level, so inputs past
    // either reference saturate at all ones or all zeros
    always_comb
    begin
        trial_nxt = trial_r;
        mask_nxt = mask_r;
        if (start)
        begin
            mask_nxt = {1'b1, {(WIDTH-1){1'b0}}};
            trial_nxt = {1'b1, {(WIDTH-1){1'b0}}};
        end
        else if (step && mask_r != '0)
        begin
            mask_nxt = mask_r >> 1;
            trial_nxt = (cmp_above ? trial_r : (trial_r & ~mask_r)) | (mask_r >> 1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            trial_r <= '0;
            mask_r <= '0;
        end
        else if (clk_en)
        begin
            trial_r <= trial_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign trial = trial_r;
    assign done = (mask_r == '0);
endmodule : sadc_sar

/* verif/sadc_analog_src.sv */
`timescale 1ns/1ps
// ideal comparator behind the channel mux; levels come from the bench
module sadc_analog_src
(
    // channel levels and selection
    input wire logic [15:0][9:0] level,
    input wire logic [3:0] analog_mux_select,
    input wire logic converter_power,
    // comparison against the trial code
    input wire logic [9:0] dac_trial,
    output logic comparator_above
);
    // unpowered comparator toggles so a stale decision is never reused
    logic flip = 1'b0;
    always #25 flip = ~flip;
    assign comparator_above = converter_power ?
        (level[analog_mux_select] >= dac_trial) : flip;
endmodule : sadc_analog_src

/* verif/sadc_ctrl_props.sv */
`timescale 1ns/1ps
module sadc_ctrl_props
#(
    parameter int CHANNELS = 16,
    parameter int ADDR_W = 8
)
(
    // clock, reset, register port
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // power modes and analog side
    input wire logic cpu_wait,
    input wire logic cpu_halt,
    input wire logic [3:0] analog_mux_select,
    input wire logic converter_power,
    input wire logic sample_hold,
    input wire logic [9:0] dac_trial,
    input wire logic comparator_above,
    // pins
    input wire logic [CHANNELS-1:0] port_pin,
    input wire logic [CHANNELS-1:0] port_pin_level
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside answer");
    a_low_upper_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h72 |-> reg_rdata[7:2] == 6'h00)
        else $error("low byte upper bits set");
    a_csr_rsvd_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h70 |-> !reg_rdata[4])
        else $error("reserved bit reads one");
    a_mux_follows: assert property (
        reg_wr && reg_addr == 8'h70 |=> {4'h0, analog_mux_select} == ($past(reg_wdata) & 8'h0F))
        else $error("mux select not channel field");
    a_power_up: assert property (
        reg_wr && reg_addr == 8'h70 && reg_wdata[5] |=> converter_power || cpu_halt)
        else $error("converter not powered");
    a_power_down: assert property (
        reg_wr && reg_addr == 8'h70 && !reg_wdata[5] |=> !converter_power)
        else $error("converter still powered");
    a_halt_off: assert property (
        cpu_halt |-> !converter_power) else $error("powered in halt");
    a_sample_soon: assert property (
        $rose(converter_power) |-> ##[0:6] (sample_hold || !converter_power))
        else $error("no sampling after power up");
    a_idle_quiet: assert property (
        !converter_power [*3] |-> !sample_hold) else $error("sampling while off");
    a_pin_sync: assert property (
        port_pin_level == $past(port_pin, 2)) else $error("pin level not passed");
endmodule : sadc_ctrl_props

bind sadc_ctrl sadc_ctrl_props #(.CHANNELS(CHANNELS), .ADDR_W(ADDR_W)) u_sadc_ctrl_props (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_wait(cpu_wait), .cpu_halt(cpu_halt), .analog_mux_select(analog_mux_select),
    .converter_power(converter_power), .sample_hold(sample_hold), .dac_trial(dac_trial),
    .comparator_above(comparator_above), .port_pin(port_pin),
    .port_pin_level(port_pin_level));

/* verif/sadc_ctrl_test.sv */
`timescale 1ns/1ps
module sadc_ctrl_test;
    logic ref_clk;
    logic reset;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic cpu_wait;
    logic cpu_halt;
    logic [3:0] analog_mux_select;
    logic converter_power;
    logic sample_hold;
    logic [9:0] dac_trial;
    logic comparator_above;
    logic [15:0] port_pin;
    logic [15:0] port_pin_level;
    logic [15:0][9:0] level;
    logic [7:0] rd_val;
    logic [15:0] pin_seen;
    int failures;
    int tests_run;
    int seed;
    int gap [2];
    int junk;
    int a;
    int b;
    sadc_ctrl u_sadc_ctrl (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
        .analog_mux_select(analog_mux_select), .converter_power(converter_power),
        .sample_hold(sample_hold), .dac_trial(dac_trial), .comparator_above(comparator_above),
        .port_pin(port_pin), .port_pin_level(port_pin_level));
    sadc_analog_src u_sadc_analog_src (.level(level), .analog_mux_select(analog_mux_select),
        .converter_power(converter_power), .dac_trial(dac_trial),
        .comparator_above(comparator_above));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check
    function automatic logic [7:0] expect_byte(input logic [9:0] v, input logic high);
        return high ? v[9:2] : {6'h00, v[1:0]};
    endfunction : expect_byte
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic poll_done();
        int n;
        n = 0;
        rd(8'h70);
        while (rd_val[7] !== 1'b1 && n < 60)
        begin
            rd(8'h70);
            n++;
        end
        check({7'h00, rd_val[7]}, 8'h01);
    endtask : poll_done
    task automatic read_result(input logic [9:0] v, input logic [7:0] csr);
        rd(8'h72);
        check(rd_val, expect_byte(v, 1'b0));
        rd(8'h71);
        check(rd_val, expect_byte(v, 1'b1));
        rd(8'h70);
        check(rd_val, csr);
    endtask : read_result
    task automatic wait_sample(input logic lvl, output int n);
        n = 0;
        while (sample_hold !== lvl && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_sample
    always @(posedge ref_clk)
    begin
        cpu_wait <= reset ? 1'b0 : 1'($random(seed));
        port_pin <= reset ? 16'h0000 : 16'($random(seed));
    end
    initial
    begin
        #(20000 * 50);
        failures++;
        report_and_stop();
    end
    initial
    begin
        seed = 32'h10d1;
        {reset, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 18'h0};
        {cpu_halt, level} = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 3; i++)
        begin
            rd(8'h70 + 8'(i));
            check(rd_val, 8'h00);
        end
        @(posedge ref_clk);
        #1 pin_seen = port_pin;
        repeat (2) @(posedge ref_clk);
        #1 check(port_pin_level[7:0], pin_seen[7:0]);
        check(port_pin_level[15:8], pin_seen[15:8]);
        @(posedge ref_clk);
        wr(8'h70, 8'h8F);
        rd(8'h70);
        check(rd_val, 8'h0F);
        wr(8'h71, 8'hFF);
        rd(8'h71);
        check(rd_val, 8'h00);
        for (int ch = 0; ch < 16; ch++)
        begin
            level[ch] <= (ch == 0) ? 10'h3FF : (ch == 1) ? 10'h000 : 10'($random(seed));
            wr(8'h70, 8'(ch));
            rd(8'h71);
            wr(8'h70, 8'h20 | 8'(ch));
            poll_done();
            read_result(level[ch], 8'h20 | 8'(ch));
        end
        level[15] <= 10'($random(seed));
        repeat (80) @(posedge ref_clk);
        wr(8'h70, 8'h2F);
        rd(8'h70);
        check(rd_val, 8'hAF);
        rd(8'h71);
        poll_done();
        read_result(level[15], 8'h2F);
        for (int f = 0; f < 2; f++)
        begin
            wr(8'h70, f ? 8'h60 : 8'h20);
            wait_sample(1'b1, junk);
            wait_sample(1'b0, a);
            wait_sample(1'b1, b);
            gap[f] = a + b;
        end
        check({7'h00, gap[1] < gap[0]}, 8'h01);
        rd(8'h71);
        poll_done();
        read_result(10'h3FF, 8'h60);
        cpu_halt <= 1'b1;
        rd(8'h71);
        repeat (60) @(posedge ref_clk);
        rd(8'h70);
        check(rd_val, 8'h60);
        cpu_halt <= 1'b0;
        poll_done();
        wr(8'h70, 8'h00);
        rd(8'h71);
        repeat (60) @(posedge ref_clk);
        rd(8'h70);
        check(rd_val, 8'h00);
        check({7'h00, converter_power}, 8'h00);
        report_and_stop();
    end
endmodule : sadc_ctrl_test
